/* File: hw/pml_lock.sv */
// Program memory lock controller: pin programming and verify, code fetch
// gating, external access latch and an AXI4-Lite register slave.
// Assumes all pins are synchronous to i_ref_clk and storage is erased once
// through the erase command before first use.

// Contract
// (R01) Two lock bits plus 32-byte encryption array.
// (R02) Encryption bytes start erased, all ones.
// (R03) Five address bits pick an encryption byte.
// (R04) Verify output is code XNOR encryption byte.
// (R05) Programmer should lock when using encryption.
// (R06) Unlocked: verify still passes through XNOR.
// (R07) Lock one blocks external table reads internally.
// (R08) Lock one latches external access at reset.
// (R09) Lock one refuses further EPROM programming.
// (R10) Both locks: all above plus no verify.
// (R11) Erase clears array, encryption, both locks.
// (R12) System keeps access pin equal to latch.
// (R13) Signature: verify 030H/031H, selects low.
// (R14) Signature returns maker then device code.
// (R15) Erased array reads all ones.
// (R16) Address on low port plus five pins.
// (R17) Verify strobe low or used as read strobe.
// (R18) Encryption index is address low five bits.
// (R19) Lock state acts at once, no reset.
module pml_lock #(
  parameter int unsigned CODE_AW  = 13,
  parameter logic [7:0]  MFR_CODE = 8'ha5, // Arbitrary value.
  parameter logic [7:0]  DEV_CODE = 8'h3c  // Arbitrary value.
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // Programmer pins.
  input  wire logic [CODE_AW-1:0]   i_program_pulse_addr,
  input  wire logic [7:0]           i_program_pulse_data,
  input  wire logic                 i_program_pulse_n,
  input  wire logic                 i_vpp_high,
  input  wire logic                 i_verify_enable_strobe_n,
  input  wire logic                 i_lock_select,
  input  wire logic                 i_signature_select_a,
  input  wire logic                 i_signature_select_b,
  output logic      [7:0]           o_port_data,
  output logic                      o_port_data_oe,
  // External access pin and the core's view of it.
  input  wire logic                 i_external_access_select,
  output logic                      o_external_access_eff,
  // Code table read from the core.
  input  wire logic                 i_fetch_valid,
  input  wire logic                 i_fetch_from_external,
  input  wire logic [CODE_AW-1:0]   i_fetch_addr,
  output logic      [7:0]           o_fetch_data,
  output logic                      o_fetch_blocked,
  // AXI4-Lite slave.
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import pml_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode from the programmer pins; used for writes and for reads.
  function automatic pml_mode_t decode_mode(
    input logic pulse_n,
    input logic strobe_n,
    input logic p_lock,
    input logic sel_a,
    input logic sel_b
  );
    pml_mode_t m;
    m = PM_IDLE;
    if (!strobe_n && pulse_n && !p_lock) begin
      if (sel_a && sel_b) begin
        m = PM_VERIFY; // (R17)
      end else if (!sel_a && !sel_b) begin
        m = PM_SIGNATURE; // (R13)
      end
    end else if (strobe_n && sel_b) begin
      if (!p_lock) begin
        m = sel_a ? PM_PROGRAM_PULSE_CODE : PM_PROGRAM_PULSE_ENC;
      end else begin
        m = sel_a ? PM_PROGRAM_PULSE_LOCK1 : PM_PROGRAM_PULSE_LOCK2;
      end
    end
    return m;
  endfunction

  logic        lock1;
  logic        lock2;
  logic [7:0]  code_v;
  logic [7:0]  code_f;
  logic [7:0]  enc_v;
  pml_mode_t   mode;
  logic        pulse_prev_r;
  logic        pulse_fall;
  logic        pin_en_r;
  logic        pin_en_nxt;
  logic        erase_r;
  logic        erase_nxt;
  logic        refused_r;
  logic        refused_nxt;
  logic        wr_code;
  logic        wr_enc;
  logic        wr_lock1;
  logic        wr_lock2;
  logic        wr_req;

  assign mode = decode_mode(i_program_pulse_n, i_verify_enable_strobe_n,
                            i_lock_select, i_signature_select_a,
                            i_signature_select_b);

  pml_store #(
    .CODE_AW (CODE_AW)
  ) u_store (
    .i_ref_clk         (i_ref_clk),
    .i_erase           (erase_r),
    .i_wr_code         (wr_code),
    .i_wr_enc          (wr_enc),
    .i_wr_lock1        (wr_lock1),
    .i_wr_lock2        (wr_lock2),
    .i_waddr           (i_program_pulse_addr),
    .i_wdata           (i_program_pulse_data),
    .i_raddr_a         (i_program_pulse_addr), // (R16)
    .i_raddr_b         (i_fetch_addr),
    .o_code_a          (code_v),
    .o_code_b          (code_f),
    .o_enc_a           (enc_v),
    .o_first_lock_bit  (lock1),
    .o_second_lock_bit (lock2)
  ); // (R01)

  ////////////////////////////////////////////////////////////////////////////
  // Programming: one write per falling program pulse with the high voltage
  // present. Lock bits stay programmable so the second can follow the first.
  assign pulse_fall = pulse_prev_r && !i_program_pulse_n && i_vpp_high;
  assign wr_req     = pulse_fall && pin_en_r && !erase_r;
  always_comb begin
    wr_code  = wr_req && (mode == PM_PROGRAM_PULSE_CODE) && !lock1; // (R09)
    wr_enc   = wr_req && (mode == PM_PROGRAM_PULSE_ENC) && !lock1; // (R09)
    wr_lock1 = wr_req && (mode == PM_PROGRAM_PULSE_LOCK1);
    wr_lock2 = wr_req && (mode == PM_PROGRAM_PULSE_LOCK2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verify and signature readout, registered onto the data port.
  // A refused verify floats the port, so pull-ups show all ones.
  logic [7:0] port_data_nxt;
  logic       port_oe_nxt;
  always_comb begin
    port_data_nxt = ERASED_BYTE;
    port_oe_nxt   = 1'b0;
    if (pin_en_r) begin
      unique case (mode)
        PM_VERIFY: begin
          port_oe_nxt   = !lock2; // (R10) (R19)
          port_data_nxt = ~(code_v ^ enc_v); // (R04) (R06)
        end
        PM_SIGNATURE: begin
          port_oe_nxt = 1'b1;
          if (16'(i_program_pulse_addr) == SIG_LO_ADDR) begin
            port_data_nxt = MFR_CODE; // (R14)
          end else if (16'(i_program_pulse_addr) == SIG_HI_ADDR) begin
            port_data_nxt = DEV_CODE; // (R14)
          end
        end
        default: begin
          port_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_port_data    <= 8'h00;
      o_port_data_oe <= 1'b0;
      pulse_prev_r   <= 1'b1;
    end else begin
      o_port_data    <= port_data_nxt;
      o_port_data_oe <= port_oe_nxt;
      pulse_prev_r   <= i_program_pulse_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External access latch. It is caught on the first edge after reset is
  // released, so no flip-flop ever loads a pin value under reset.
  logic rst_prev_r;
  logic ea_lat_r;
  logic ea_lat_nxt;
  always_comb begin
    ea_lat_nxt = ea_lat_r;
    if (rst_prev_r) begin
      ea_lat_nxt = i_external_access_select; // (R08)
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rst_prev_r <= 1'b1;
      ea_lat_r   <= 1'b0;
    end else begin
      rst_prev_r <= 1'b0;
      ea_lat_r   <= ea_lat_nxt;
    end
  end

  // Parts with the first lock set use the latch; the pin must agree with it. (R12)
  assign o_external_access_eff = lock1 ? ea_lat_r // (R08) (R19)
                                       : i_external_access_select;

  ////////////////////////////////////////////////////////////////////////////
  // Code table reads from the core. Running from external memory with the
  // first lock set must not see internal bytes.
  logic [7:0] fetch_data_nxt;
  logic       fetch_blk_nxt;
  always_comb begin
    fetch_data_nxt = o_fetch_data;
    fetch_blk_nxt  = o_fetch_blocked;
    if (i_fetch_valid) begin
      fetch_blk_nxt  = lock1 && i_fetch_from_external; // (R07)
      fetch_data_nxt = fetch_blk_nxt ? FETCH_BLOCK_BYTE : code_f;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_fetch_data    <= 8'h00;
      o_fetch_blocked <= 1'b0;
    end else begin
      o_fetch_data    <= fetch_data_nxt;
      o_fetch_blocked <= fetch_blk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data are taken together, and the
  // response is held until the master accepts it.
  logic       wr_take;
  logic       bvalid_nxt;
  logic [1:0] bresp_nxt;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_take       = s_axi_awready;

  always_comb begin
    bvalid_nxt  = s_axi_bvalid && !s_axi_bready;
    bresp_nxt   = s_axi_bresp;
    pin_en_nxt  = pin_en_r;
    erase_nxt   = 1'b0;
    refused_nxt = refused_r;
    if (wr_take) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      unique case (s_axi_awaddr)
        CTRL_OFS: begin
          if (s_axi_wstrb[0]) begin
            pin_en_nxt = s_axi_wdata[CTRL_PIN_EN_BIT];
            erase_nxt  = s_axi_wdata[CTRL_ERASE_BIT]; // (R11)
          end
        end
        STATUS_OFS: begin
          if (s_axi_wstrb[0] && s_axi_wdata[ST_REFUSED_BIT]) begin
            refused_nxt = 1'b0;
          end
        end
        SIG_OFS: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    // A refused programming pulse sets the flag; set wins over clear.
    if (wr_req && lock1 &&
        (mode == PM_PROGRAM_PULSE_CODE || mode == PM_PROGRAM_PULSE_ENC)) begin
      refused_nxt = 1'b1; // (R09)
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      pin_en_r     <= CTRL_PIN_EN_RST;
      erase_r      <= 1'b0;
      refused_r    <= 1'b0;
    end else begin
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp  <= bresp_nxt;
      pin_en_r     <= pin_en_nxt;
      erase_r      <= erase_nxt;
      refused_r    <= refused_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side: one read at a time, data registered with the
  // valid so the master sees a stable word.
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  logic        rvalid_nxt;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS: begin
          rdata_nxt[CTRL_PIN_EN_BIT] = pin_en_r;
        end
        STATUS_OFS: begin
          rdata_nxt[ST_LOCK1_BIT]   = lock1;
          rdata_nxt[ST_LOCK2_BIT]   = lock2;
          rdata_nxt[ST_EA_LAT_BIT]  = ea_lat_r;
          rdata_nxt[ST_EA_EFF_BIT]  = o_external_access_eff;
          rdata_nxt[ST_REFUSED_BIT] = refused_r;
        end
        SIG_OFS: begin
          rdata_nxt[15:0] = {DEV_CODE, MFR_CODE};
        end
        default: begin
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rresp_nxt;
    end
  end

endmodule

/* File: hw/pml_store.sv */
// Nonvolatile storage model: code array, encryption array and lock bits.
// Assumes writes arrive as single-cycle strobes from the lock controller.
module pml_store #(
  parameter int unsigned CODE_AW = 13
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_erase,
  input  wire logic                 i_wr_code,
  input  wire logic                 i_wr_enc,
  input  wire logic                 i_wr_lock1,
  input  wire logic                 i_wr_lock2,
  input  wire logic [CODE_AW-1:0]   i_waddr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic [CODE_AW-1:0]   i_raddr_a,
  input  wire logic [CODE_AW-1:0]   i_raddr_b,
  output logic      [7:0]           o_code_a,
  output logic      [7:0]           o_code_b,
  output logic      [7:0]           o_enc_a,
  output logic                      o_first_lock_bit,
  output logic                      o_second_lock_bit
);
  import pml_pkg::*;

  logic [7:0] code_r [2**CODE_AW];
  logic [7:0] enc_r  [ENC_BYTES];
  logic       lock1_r;
  logic       lock2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Code and encryption cells only go from one to zero, so a write is an AND with the old byte.
  // Erase restores every cell, the encryption array and both locks. (R11)
  always_ff @(posedge i_ref_clk) begin
    if (i_erase) begin
      for (int i = 0; i < 2**CODE_AW; i++) begin
        code_r[i] <= ERASED_BYTE; // (R15)
      end
      for (int j = 0; j < ENC_BYTES; j++) begin
        enc_r[j] <= ERASED_BYTE; // (R02)
      end
      lock1_r <= 1'b0;
      lock2_r <= 1'b0;
    end else begin
      if (i_wr_code) begin
        code_r[i_waddr] <= code_r[i_waddr] & i_wdata;
      end
      if (i_wr_enc) begin
        enc_r[i_waddr[ENC_AW-1:0]] <= enc_r[i_waddr[ENC_AW-1:0]] & i_wdata;
      end
      if (i_wr_lock1) begin
        lock1_r <= 1'b1;
      end
      if (i_wr_lock2) begin
        lock2_r <= 1'b1;
      end
    end
  end

  // Read ports are combinational; the controller registers what leaves.
  assign o_code_a          = code_r[i_raddr_a];
  assign o_code_b          = code_r[i_raddr_b];
  assign o_enc_a           = enc_r[i_raddr_a[ENC_AW-1:0]]; // (R03) (R18)
  assign o_first_lock_bit  = lock1_r;
  assign o_second_lock_bit = lock2_r;

endmodule

/* File: shared/pml_pkg.sv */
// Constants and types shared by the program memory lock and verify block.
// Assumes a single clock domain and an AXI4-Lite register bus.
package pml_pkg;

  // Array geometry.
  localparam int unsigned ENC_BYTES = 32;
  localparam int unsigned ENC_AW    = 5;
  localparam int unsigned DATA_W    = 8;

  // Erased EPROM cells and encryption bytes read as all ones.
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Signature locations, compared against the zero-extended address.
  localparam logic [15:0] SIG_LO_ADDR = 16'h0030;
  localparam logic [15:0] SIG_HI_ADDR = 16'h0031;

  // Register byte offsets.
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] SIG_OFS    = 4'h8;

  // Control fields.
  localparam int unsigned CTRL_PIN_EN_BIT = 0;
  localparam int unsigned CTRL_ERASE_BIT  = 1;
  localparam logic        CTRL_PIN_EN_RST = 1'b1;

  // Status fields.
  localparam int unsigned ST_LOCK1_BIT   = 0;
  localparam int unsigned ST_LOCK2_BIT   = 1;
  localparam int unsigned ST_EA_LAT_BIT  = 2;
  localparam int unsigned ST_EA_EFF_BIT  = 3;
  localparam int unsigned ST_REFUSED_BIT = 4;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Value shown on a code fetch that the lock refuses.
  localparam logic [7:0] FETCH_BLOCK_BYTE = 8'h00;

  // Pin mode selected by the programmer's mode pins.
  typedef enum logic [2:0] {
    PM_IDLE,
    PM_PROGRAM_PULSE_CODE,
    PM_PROGRAM_PULSE_ENC,
    PM_PROGRAM_PULSE_LOCK1,
    PM_PROGRAM_PULSE_LOCK2,
    PM_VERIFY,
    PM_SIGNATURE
  } pml_mode_t;

endpackage

/* File: tb/pml_lock_assertions.sv */
// Port checker for the program memory lock and verify block.
// Assumes it is bound into pml_lock and shares its clock and reset.
module pml_lock_assertions import pml_pkg::*; #(
  parameter int unsigned CODE_AW  = 13,
  parameter logic [7:0]  MFR_CODE = 8'ha5,
  parameter logic [7:0]  DEV_CODE = 8'h3c
) (
  input wire logic               i_ref_clk,
  input wire logic               i_rst,
  input wire logic [CODE_AW-1:0] i_program_pulse_addr,
  input wire logic               i_program_pulse_n,
  input wire logic               i_verify_enable_strobe_n,
  input wire logic               i_lock_select,
  input wire logic               i_signature_select_a,
  input wire logic               i_signature_select_b,
  input wire logic [7:0]         o_port_data,
  input wire logic               o_port_data_oe,
  input wire logic               i_external_access_select,
  input wire logic               o_external_access_eff,
  input wire logic               i_fetch_valid,
  input wire logic               i_fetch_from_external,
  input wire logic [7:0]         o_fetch_data,
  input wire logic               o_fetch_blocked,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_bvalid,
  input wire logic [3:0]         s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Signature mode on the pins, sampled at one edge.
  sequence s_sig(logic [15:0] a);
    !i_verify_enable_strobe_n && !i_lock_select && i_program_pulse_n &&
    !i_signature_select_a && !i_signature_select_b &&
    16'(i_program_pulse_addr) == a;
  endsequence

  a_sig_maker: assert property (s_sig(SIG_LO_ADDR) |=>
    o_port_data_oe && o_port_data == MFR_CODE)
    else $error("maker code wrong");
  a_sig_device: assert property (s_sig(SIG_HI_ADDR) |=>
    o_port_data_oe && o_port_data == DEV_CODE)
    else $error("device code wrong");
  a_oe_cause: assert property (o_port_data_oe |->
    $past(!i_verify_enable_strobe_n)) else $error("port driven unasked");
  a_fetch_zero: assert property (o_fetch_blocked |->
    o_fetch_data == FETCH_BLOCK_BYTE) else $error("blocked fetch leaks");
  a_fetch_inner: assert property (i_fetch_valid &&
    !i_fetch_from_external |=> !o_fetch_blocked)
    else $error("internal fetch refused");
  a_ea_follow: assert property ($changed(o_external_access_eff) |->
    o_external_access_eff == i_external_access_select)
    else $error("access select moved alone");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid |=> s_axi_bvalid) else $error("no write response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read response");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 4'hc |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_reset_quiet: assert property (disable iff (1'b0) i_rst |=>
    !o_port_data_oe && !s_axi_bvalid && !s_axi_rvalid && !o_fetch_blocked)
    else $error("outputs busy in reset");
endmodule

bind pml_lock pml_lock_assertions #(.CODE_AW(CODE_AW),
  .MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) u_chk (.*);

/* File: tb/pml_lock_test.sv */
// Self-checking bench for the program memory lock and verify block.
// Assumes the programmer model and the bound checker.
module pml_lock_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pml_pkg::*;

  localparam int unsigned AW  = 13;
  localparam logic [7:0]  MFR = 8'h5e; // Arbitrary value.
  localparam logic [7:0]  DEV = 8'hc3; // Arbitrary value.

  logic          clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]    awaddr, araddr, wstrb;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [AW-1:0] p_addr, f_addr;
  logic [7:0]    p_data, port_data, f_data;
  logic          p_pulse_n, p_vpp, p_strobe_n, p_lock_sel, p_sel_a;
  logic          p_sel_b, port_oe, ea_pin, ea_eff, f_valid, f_ext, f_blk;
  int            num_errors = 0;
  int            compares = 0;

  pml_lock #(.CODE_AW(AW), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_program_pulse_addr(p_addr),
    .i_program_pulse_data(p_data), .i_program_pulse_n(p_pulse_n),
    .i_vpp_high(p_vpp), .i_verify_enable_strobe_n(p_strobe_n),
    .i_lock_select(p_lock_sel), .i_signature_select_a(p_sel_a),
    .i_signature_select_b(p_sel_b), .o_port_data(port_data),
    .o_port_data_oe(port_oe), .i_external_access_select(ea_pin),
    .o_external_access_eff(ea_eff), .i_fetch_valid(f_valid),
    .i_fetch_from_external(f_ext), .i_fetch_addr(f_addr),
    .o_fetch_data(f_data), .o_fetch_blocked(f_blk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  pml_program_pulse_model #(.AW(AW)) u_program_pulse (
    .i_ref_clk(clk), .i_port_data(port_data), .i_port_data_oe(port_oe),
    .o_addr(p_addr), .o_data(p_data), .o_pulse_n(p_pulse_n),
    .o_vpp(p_vpp), .o_strobe_n(p_strobe_n), .o_lock_sel(p_lock_sel),
    .o_sel_a(p_sel_a), .o_sel_b(p_sel_b));

  ////////////////////////////////////////////////////////////////////
  // Compare, bus and pin helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (!bvalid);
    bready  <= 1'b0;
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [31:0] e,
                         input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready  <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic vchk(input logic s, input logic [15:0] a,
                      input logic [7:0] e, input logic eoe);
    logic [7:0] q;
    logic       o;
    u_program_pulse.rd(s, a[AW-1:0], q, o);
    chk({31'h0, o}, {31'h0, eoe});
    chk({24'h0, q}, {24'h0, e});
  endtask

  task automatic fchk(input logic x, input logic [15:0] a,
                      input logic [7:0] e, input logic eb);
    @(posedge clk);
    f_valid <= 1'b1;
    f_ext   <= x;
    f_addr  <= a[AW-1:0];
    @(posedge clk);
    f_valid <= 1'b0;
    @(posedge clk);
    chk({24'h0, f_data}, {24'h0, e});
    chk({31'h0, f_blk}, {31'h0, eb});
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_erase();
    reg_chk(CTRL_OFS, 32'h1, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h3);
    reg_chk(CTRL_OFS, 32'h1, RESP_OKAY);
    reg_chk(STATUS_OFS, 32'hc, RESP_OKAY);
    reg_chk(SIG_OFS, {16'h0, DEV, MFR}, RESP_OKAY);
    vchk(1'b0, 16'h0025, ERASED_BYTE, 1'b1);
    $display("test erase finished");
  endtask

  task automatic t_crypt();
    u_program_pulse.program_pulse(1'b0, 1'b1, 13'h0025, 8'h5a);
    vchk(1'b0, 16'h0025, 8'h5a, 1'b1);
    u_program_pulse.program_pulse(1'b0, 1'b0, 13'h0005, 8'h0f);
    vchk(1'b0, 16'h0025, 8'haa, 1'b1);
    vchk(1'b0, 16'h0045, 8'h0f, 1'b1);
    vchk(1'b0, 16'h0026, 8'hff, 1'b1);
    fchk(1'b1, 16'h0025, 8'h5a, 1'b0);
    $display("test encryption finished");
  endtask

  task automatic t_lock1();
    u_program_pulse.program_pulse(1'b1, 1'b1, 13'h0000, 8'h00);
    reg_chk(STATUS_OFS, 32'hd, RESP_OKAY);
    fchk(1'b1, 16'h0025, FETCH_BLOCK_BYTE, 1'b1);
    fchk(1'b0, 16'h0025, 8'h5a, 1'b0);
    u_program_pulse.program_pulse(1'b0, 1'b1, 13'h0027, 8'h00);
    vchk(1'b0, 16'h0027, 8'hff, 1'b1);
    reg_chk(STATUS_OFS, 32'h1d, RESP_OKAY);
    axi_wr(STATUS_OFS, 32'h10);
    reg_chk(STATUS_OFS, 32'hd, RESP_OKAY);
    @(posedge clk);
    ea_pin <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, ea_eff}, 32'h1);
    ea_pin <= 1'b1;
    $display("test first lock finished");
  endtask

  task automatic t_lock2();
    u_program_pulse.program_pulse(1'b1, 1'b0, 13'h0000, 8'h00);
    vchk(1'b0, 16'h0025, 8'hff, 1'b0);
    vchk(1'b1, 16'h0030, MFR, 1'b1);
    vchk(1'b1, 16'h0031, DEV, 1'b1);
    reg_chk(STATUS_OFS, 32'hf, RESP_OKAY);
    reg_chk(4'hc, 32'h0, RESP_SLVERR);
    axi_wr(CTRL_OFS, 32'h3);
    reg_chk(STATUS_OFS, 32'hc, RESP_OKAY);
    vchk(1'b0, 16'h0025, ERASED_BYTE, 1'b1);
    fchk(1'b1, 16'h0025, ERASED_BYTE, 1'b0);
    $display("test second lock finished");
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Clock, main sequence and watchdog.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    {ea_pin, f_valid, f_ext, f_addr} = {1'b1, 2'h0, 13'h0000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_erase();
    t_crypt();
    t_lock1();
    t_lock2();
    give_verdict();
  end

  // A hung handshake ends here; the tests need well under 2000 cycles.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule

/* File: tb/pml_program_pulse_model.sv */
// Programmer model driving the pins of the lock and verify block.
// Assumes the bench calls program_pulse and rd one at a time.
module pml_program_pulse_model #(
  parameter int unsigned AW = 13
) (
  input  wire logic          i_ref_clk,
  input  wire logic [7:0]    i_port_data,
  input  wire logic          i_port_data_oe,
  output logic      [AW-1:0] o_addr,
  output logic      [7:0]    o_data,
  output logic               o_pulse_n,
  output logic               o_vpp,
  output logic               o_strobe_n,
  output logic               o_lock_sel,
  output logic               o_sel_a,
  output logic               o_sel_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins: no pulse, no high voltage, strobe high.
  initial begin
    o_addr     = '0;
    o_data     = 8'h00;
    {o_pulse_n, o_strobe_n, o_sel_a, o_sel_b} = 4'hf;
    {o_vpp, o_lock_sel} = 2'h0;
  end

  // One program pulse; ls and sa pick code, table or a lock bit.
  task automatic program_pulse(input logic ls, input logic sa,
                      input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_strobe_n <= 1'b1;
    o_lock_sel <= ls;
    o_sel_a    <= sa;
    o_sel_b    <= 1'b1;
    o_addr     <= a;
    o_data     <= d;
    o_vpp      <= 1'b1;
    @(posedge i_ref_clk);
    o_pulse_n  <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    o_pulse_n  <= 1'b1;
    o_vpp      <= 1'b0;
    o_data     <= ~d; // A released bus must not echo the old byte.
  endtask

  // Verify read; sig pulls both selects low for the signature.
  task automatic rd(input logic sig, input logic [AW-1:0] a,
                    output logic [7:0] q, output logic oe);
    @(posedge i_ref_clk);
    o_strobe_n <= 1'b0;
    o_lock_sel <= 1'b0;
    o_sel_a    <= !sig;
    o_sel_b    <= !sig;
    o_addr     <= a;
    repeat (3) @(posedge i_ref_clk);
    oe = i_port_data_oe;
    q  = oe ? i_port_data : 8'hff; // Pull-ups lift an undriven port.
    o_strobe_n <= 1'b1;
  endtask
endmodule
